// *** src/dbgbk_pkg.sv ***
// Package with command codes, status bit positions and reset values for the debug breakpoint block
package dbgbk_pkg;

   // Serial debug command codes, already decoded from the wire by the link front end
   localparam logic [7:0] CMD_READ_STATUS = 8'he4;
   localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
   localparam logic [7:0] CMD_MATCH_READ = 8'he2;
   localparam logic [7:0] CMD_MATCH_WRITE = 8'hc2;
   localparam logic [7:0] CMD_HALT_REQUEST = 8'h90;
   localparam logic [7:0] CMD_RESUME = 8'h08;
   localparam logic [7:0] CMD_TRACE_ONE = 8'h10;
   localparam logic [7:0] CMD_RESUME_TAGGED = 8'h18;

   // Bit positions inside debug_status_control
   localparam int HALT_PERMIT_BIT = 7;
   localparam int HALT_ACTIVE_BIT = 6;
   localparam int BKPT_ENABLE_BIT = 5;
   localparam int FORCE_TAG_BIT = 4;
   localparam int CLOCK_SELECT_BIT = 3;
   localparam int LOW_POWER_STATUS_BIT = 2;
   localparam int LOW_POWER_FAIL_BIT = 1;
   localparam int SLOW_ACCESS_FAIL_BIT = 0;

   // Register widths
   localparam int STATUS_WIDTH = 8;
   localparam int MATCH_WIDTH = 16;

   // Values after reset
   localparam logic RST_HALT_PERMIT = 1'b0;
   localparam logic RST_BKPT_ENABLE = 1'b0;
   localparam logic RST_FORCE_TAG = 1'b0;
   localparam logic RST_CLOCK_SELECT = 1'b0;
   localparam logic RST_LOW_POWER_FAIL = 1'b0;
   localparam logic [MATCH_WIDTH-1:0] RST_MATCH_ADDR = 16'h0000;

   // Halt state of the CPU as seen by the debug controller
   typedef enum logic {
      DBGBK_RUN,
      DBGBK_HALTED
   } dbgbk_state_e;

endpackage

// *** src/dbgbk_top.sv ***
// Breakpoint comparator and status/control registers of the single-wire debug controller
`timescale 1ns/1ps

// Overview of operation
// - Compare CPU address with 16-bit match register
// - Forced mode halts at next instruction boundary
// - Tagged mode halts when marked opcode executes
// - Breakpoint enable resets low, blocks breakpoint requests but not host halt requests
// - Bit 4 selects forced (1) or tagged (0)
// - 8-bit status/control, serial commands only
// - Halt-permit writes ignored while halted
// - Four status bits are read-only
// - Bit 7 permits halt, cleared by reset
// - Bit 6 shows halted debug mode
// - Bit 3 selects debug clock, reset 0
// - Bit 2 shows wait/stop or woken from it
// - Halt request wakes CPU from wait/stop
// - Bit 1 flags memory access lost to wait/stop
// - Slow-access failure bit always reads 0
// - Match register reachable only by serial commands
// - Codes e4/c4 read/write status/control
// - Codes e2/c2 read/write match register
// - Halt request ignored when halt-permit is 0
module dbgbk_top
   import dbgbk_pkg::*;
#(
   parameter int ADDR_WIDTH = MATCH_WIDTH
) (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // Decoded serial debug commands
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_CODE_I,
   input wire logic [15:0] CMD_WDATA_I,
   output logic RSP_VALID_O,
   output logic [15:0] RSP_DATA_O,
   // Debug memory access commands issued by the link front end
   input wire logic MEM_ACC_I,
   output logic MEM_ACC_FAIL_O,
   // CPU side
   input wire logic [ADDR_WIDTH-1:0] CPU_ADDR_I,
   input wire logic CPU_ACCESS_I,
   input wire logic CPU_FETCH_I,
   input wire logic CPU_BOUNDARY_I,
   input wire logic CPU_TAG_AT_END_I,
   input wire logic CPU_LOW_POWER_I,
   output logic TAG_O,
   output logic HALT_ENTER_O,
   output logic RESUME_O,
   output logic TRACE_O,
   output logic HALT_ACTIVE_O,
   output logic DEBUG_CLK_SEL_O
);

   // Control and status state
   // Every flop has a _nxt partner computed in one of several combinational processes
   dbgbk_state_e state_r, state_nxt;
   logic halt_permit_r, halt_permit_nxt;
   logic bkpt_enable_r, bkpt_enable_nxt;
   logic force_tag_r, force_tag_nxt;
   logic clock_select_r, clock_select_nxt;
   logic low_power_fail_r, low_power_fail_nxt;
   logic woken_r, woken_nxt;
   logic [MATCH_WIDTH-1:0] match_addr_r, match_addr_nxt;

   // Breakpoint state
   // The pending flag bridges a forced hit to the next instruction boundary
   logic force_pend_r, force_pend_nxt;
   logic tag_r, tag_nxt;

   // Outputs held in flops
   // Pulses last one cycle; the answer word holds until it is replaced
   logic rsp_valid_r, rsp_valid_nxt;
   logic [15:0] rsp_data_r, rsp_data_nxt;
   logic mem_fail_r, mem_fail_nxt;
   logic halt_enter_r, halt_enter_nxt;
   logic resume_r, resume_nxt;
   logic trace_r, trace_nxt;

   // Decode helpers
   // Combinational names only, no state behind them
   logic halted;
   logic addr_hit;
   logic bkpt_armed;
   logic cmd_halt_req;
   logic cmd_resume_any;
   logic enter_halt;
   logic [STATUS_WIDTH-1:0] status_byte;

   // Command decode is used for every code, so keep it in one place
   // A code counts only while the valid strobe is high; the code lines are free otherwise
   function automatic logic is_cmd(input logic v, input logic [7:0] c, input logic [7:0] k);
      is_cmd = v && (c == k);
   endfunction

   // Compare only the low 16 address lines against the match value
   // Address lines above the match width are not compared, so a wider bus aliases
   function automatic logic addr_match(input logic [ADDR_WIDTH-1:0] a,
                                       input logic [MATCH_WIDTH-1:0] m);
      addr_match = (a[MATCH_WIDTH-1:0] == m);
   endfunction

   assign halted = (state_r == DBGBK_HALTED);

   // Comparator; debug-command accesses while halted never arm a breakpoint
   // Arming also needs halt permit: a request for a mode that cannot be entered would only
   // leave a stale pending hit behind
   always_comb begin
      addr_hit = addr_match(CPU_ADDR_I, match_addr_r);
      bkpt_armed = bkpt_enable_r && halt_permit_r && !halted;
   end

   // Command classification
   // Resume codes are decoded in any state; the state machine ignores them while running
   always_comb begin
      cmd_halt_req = is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_HALT_REQUEST) && halt_permit_r;
      cmd_resume_any = is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_RESUME) ||
                       is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_TRACE_ONE) ||
                       is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_RESUME_TAGGED);
   end

   // Status byte as seen by the read-status command
   // Bit 2 stays up after a wake into halted mode, so the host can tell why the CPU stopped
   always_comb begin
      status_byte = '0;
      status_byte[HALT_PERMIT_BIT] = halt_permit_r;
      status_byte[HALT_ACTIVE_BIT] = halted;
      status_byte[BKPT_ENABLE_BIT] = bkpt_enable_r;
      status_byte[FORCE_TAG_BIT] = force_tag_r;
      status_byte[CLOCK_SELECT_BIT] = clock_select_r;
      status_byte[LOW_POWER_STATUS_BIT] = CPU_LOW_POWER_I || woken_r;
      status_byte[LOW_POWER_FAIL_BIT] = low_power_fail_r;
      status_byte[SLOW_ACCESS_FAIL_BIT] = 1'b0; // No slow memory here
   end

   // Breakpoint tracking: forced hits wait for a boundary, tagged hits ride with the opcode
   // A forced hit between boundaries is remembered, so a data access halts only once its
   // instruction completes; disarming drops the pending hit so it cannot fire later
   always_comb begin
      force_pend_nxt = force_pend_r;
      tag_nxt = 1'b0;
      if (!bkpt_armed) begin
         force_pend_nxt = 1'b0;
      end else if (force_tag_r) begin
         // Any access counts, even a data access; pending survives until a boundary
         if (CPU_ACCESS_I && addr_hit) begin
            force_pend_nxt = 1'b1;
         end else if (CPU_BOUNDARY_I) begin
            force_pend_nxt = 1'b0;
         end
      end else begin
         force_pend_nxt = 1'b0;
         // Only an opcode fetch is marked; data accesses at the match address pass
         tag_nxt = CPU_ACCESS_I && CPU_FETCH_I && addr_hit;
      end
   end

   // Halt entry sources; a hit and a boundary in one cycle still halts at that boundary
   // The host's halt request is looked at first; nothing enters halt while already halted
   always_comb begin
      enter_halt = 1'b0;
      if (!halted) begin
         if (cmd_halt_req) begin
            enter_halt = 1'b1; // Also wakes wait/stop
         end else if (bkpt_armed && force_tag_r && CPU_BOUNDARY_I &&
                      (force_pend_r || (CPU_ACCESS_I && addr_hit))) begin
            enter_halt = 1'b1;
         end else if (bkpt_armed && !force_tag_r && CPU_TAG_AT_END_I) begin
            enter_halt = 1'b1;
         end
      end
   end

   // Halt state machine and its strobes to the CPU
   // Strobes are one-cycle pulses; the CPU side turns them into its halt and resume actions
   always_comb begin
      state_nxt = state_r;
      woken_nxt = woken_r;
      halt_enter_nxt = 1'b0;
      resume_nxt = 1'b0;
      trace_nxt = 1'b0;
      unique case (state_r)
         DBGBK_RUN: begin
            // Only the running state can take a halt entry
            if (enter_halt) begin
               state_nxt = DBGBK_HALTED;
               halt_enter_nxt = 1'b1;
               woken_nxt = CPU_LOW_POWER_I; // Remember it came out of wait/stop
            end
         end
         DBGBK_HALTED: begin
            // Resume commands only act in halted mode; elsewhere they are ignored
            if (cmd_resume_any) begin
               state_nxt = DBGBK_RUN;
               woken_nxt = 1'b0;
               resume_nxt = 1'b1;
               trace_nxt = is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_TRACE_ONE);
            end
         end
      endcase
   end

   // Serial register writes; status bits have no write path at all
   // Halt permit is frozen while halted, so a write cannot forbid the mode already in use
   always_comb begin
      halt_permit_nxt = halt_permit_r;
      bkpt_enable_nxt = bkpt_enable_r;
      force_tag_nxt = force_tag_r;
      clock_select_nxt = clock_select_r;
      match_addr_nxt = match_addr_r;
      if (is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_WRITE_CONTROL)) begin
         if (!halted) begin
            halt_permit_nxt = CMD_WDATA_I[HALT_PERMIT_BIT];
         end
         // The other control bits take the payload in any state
         bkpt_enable_nxt = CMD_WDATA_I[BKPT_ENABLE_BIT];
         force_tag_nxt = CMD_WDATA_I[FORCE_TAG_BIT];
         clock_select_nxt = CMD_WDATA_I[CLOCK_SELECT_BIT];
      end
      // The match register takes the whole 16-bit payload
      if (is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_MATCH_WRITE)) begin
         match_addr_nxt = CMD_WDATA_I[MATCH_WIDTH-1:0];
      end
   end

   // Memory access outcome: each access command overwrites the failure flag
   // Limitation: failure is judged from the low-power level in the access cycle, so an
   // access racing a wait or stop instruction in that same cycle is reported as failed
   always_comb begin
      low_power_fail_nxt = low_power_fail_r;
      mem_fail_nxt = 1'b0;
      // Without an access the last outcome stays visible in the status byte
      if (MEM_ACC_I) begin
         // A CPU in wait/stop cannot service the access unless halted
         mem_fail_nxt = CPU_LOW_POWER_I && !halted;
         low_power_fail_nxt = CPU_LOW_POWER_I && !halted;
      end
   end

   // Read answers one cycle after the command
   // Answer data stays in its flops until the next read, so a late host still sees it
   always_comb begin
      rsp_valid_nxt = 1'b0;
      rsp_data_nxt = rsp_data_r;
      if (is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_READ_STATUS)) begin
         rsp_valid_nxt = 1'b1;
         // Status answers are padded with zeros to the 16-bit answer word
         rsp_data_nxt = {8'h00, status_byte};
      end else if (is_cmd(CMD_VALID_I, CMD_CODE_I, CMD_MATCH_READ)) begin
         rsp_valid_nxt = 1'b1;
         rsp_data_nxt = match_addr_r;
      end
   end

   // Halt state and its strobes; a reset always leaves the CPU running
   // The strobes are registered so the CPU never sees a glitch from the command decode
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         state_r <= DBGBK_RUN;
         woken_r <= 1'b0;
         halt_enter_r <= 1'b0;
         resume_r <= 1'b0;
         trace_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         woken_r <= woken_nxt;
         halt_enter_r <= halt_enter_nxt;
         resume_r <= resume_nxt;
         trace_r <= trace_nxt;
      end
   end

   // Control registers; a normal reset clears halt permit and every control bit
   // Permit is cleared only here or by a control write while running, so it survives any number of halt and resume cycles
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         halt_permit_r <= RST_HALT_PERMIT;
         bkpt_enable_r <= RST_BKPT_ENABLE;
         force_tag_r <= RST_FORCE_TAG;
         clock_select_r <= RST_CLOCK_SELECT;
         match_addr_r <= RST_MATCH_ADDR;
      end else begin
         halt_permit_r <= halt_permit_nxt;
         bkpt_enable_r <= bkpt_enable_nxt;
         force_tag_r <= force_tag_nxt;
         clock_select_r <= clock_select_nxt;
         match_addr_r <= match_addr_nxt;
      end
   end

   // Breakpoint flops
   // A pending hit never outlives a reset, so a stale match cannot halt the next session
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         force_pend_r <= 1'b0;
         tag_r <= 1'b0;
      end else begin
         force_pend_r <= force_pend_nxt;
         tag_r <= tag_nxt;
      end
   end

   // Memory access outcome flops
   // The failure flag is only cleared by reset or by the next successful access
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         low_power_fail_r <= RST_LOW_POWER_FAIL;
         mem_fail_r <= 1'b0;
      end else begin
         low_power_fail_r <= low_power_fail_nxt;
         mem_fail_r <= mem_fail_nxt;
      end
   end

   // Read answer flops
   // The answer word is cleared by reset so no old data is shown as a first answer
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r <= 16'h0000;
      end else begin
         rsp_valid_r <= rsp_valid_nxt;
         rsp_data_r <= rsp_data_nxt;
      end
   end

   // Port drive, all from flops
   // Answers to the host
   assign RSP_VALID_O = rsp_valid_r;
   assign RSP_DATA_O = rsp_data_r;
   assign MEM_ACC_FAIL_O = mem_fail_r;

   // Strobes to the CPU
   assign TAG_O = tag_r;
   assign HALT_ENTER_O = halt_enter_r;
   assign RESUME_O = resume_r;
   assign TRACE_O = trace_r;

   // Levels; halt-active follows the state flop directly, so it never lags the enter strobe
   assign HALT_ACTIVE_O = halted;
   assign DEBUG_CLK_SEL_O = clock_select_r;

endmodule

// *** tb/dbgbk_chk.sv ***
// Port assertions for the debug breakpoint block
`timescale 1ns/1ps
module dbgbk_chk
   import dbgbk_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_CODE_I,
   input wire logic RSP_VALID_O,
   input wire logic [15:0] RSP_DATA_O,
   input wire logic CPU_ACCESS_I,
   input wire logic CPU_FETCH_I,
   input wire logic CPU_LOW_POWER_I,
   input wire logic TAG_O,
   input wire logic HALT_ENTER_O,
   input wire logic HALT_ACTIVE_O
);
   // One clock domain, so clock and reset are stated once
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_read_answers:
      assert property (CMD_VALID_I && (CMD_CODE_I == CMD_READ_STATUS ||
         CMD_CODE_I == CMD_MATCH_READ) |=> RSP_VALID_O) else $error("read not answered");
   a_answer_cause:
      assert property (RSP_VALID_O |-> $past(CMD_VALID_I) && ($past(CMD_CODE_I) ==
         CMD_READ_STATUS || $past(CMD_CODE_I) == CMD_MATCH_READ)) else $error("stray answer");
   a_slow_fail_clear:
      assert property (RSP_VALID_O && $past(CMD_CODE_I) == CMD_READ_STATUS
         |-> !RSP_DATA_O[SLOW_ACCESS_FAIL_BIT]) else $error("slow fail bit set");
   a_halt_bit_shown:
      assert property (RSP_VALID_O && $past(CMD_CODE_I) == CMD_READ_STATUS
         |-> RSP_DATA_O[HALT_ACTIVE_BIT] == $past(HALT_ACTIVE_O)) else $error("halt bit wrong");
   a_low_power_shown:
      assert property (RSP_VALID_O && $past(CMD_CODE_I) == CMD_READ_STATUS &&
         $past(CPU_LOW_POWER_I) |-> RSP_DATA_O[LOW_POWER_STATUS_BIT]) else $error("wait bit low");
   a_quiet_halted:
      assert property (HALT_ACTIVE_O && $past(HALT_ACTIVE_O) |-> !TAG_O && !HALT_ENTER_O)
         else $error("request while halted");
   a_enter_starts:
      assert property (HALT_ENTER_O |-> HALT_ACTIVE_O && !$past(HALT_ACTIVE_O))
         else $error("enter without new halt");
   a_tag_from_fetch:
      assert property (TAG_O |-> $past(CPU_ACCESS_I) && $past(CPU_FETCH_I))
         else $error("tag without fetch");
endmodule

bind dbgbk_top dbgbk_chk dbgbk_chk_i (.CLK_I, .RST_B_I, .CMD_VALID_I, .CMD_CODE_I,
   .RSP_VALID_O, .RSP_DATA_O, .CPU_ACCESS_I, .CPU_FETCH_I, .CPU_LOW_POWER_I, .TAG_O,
   .HALT_ENTER_O, .HALT_ACTIVE_O);

// *** tb/dbgbk_host.sv ***
// Model of the debug host that issues decoded serial commands
`timescale 1ns/1ps
module dbgbk_host (
   input wire logic clk_i,
   input wire logic rsp_valid_i,
   input wire logic [15:0] rsp_data_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_wdata_o
);
   // Idle lines at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
   end
   // One command per call; lines are inverted on release so stale data never looks current
   task automatic send(input logic [7:0] c, input logic [15:0] d, output logic v,
      output logic [15:0] r);
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      cmd_code_o = ~c;
      cmd_wdata_o = ~d;
      v = rsp_valid_i;
      r = rsp_data_i;
   endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the debug breakpoint block
`timescale 1ns/1ps
module testbench;
   import dbgbk_pkg::*;
   logic clk = 1'b0;
   logic rst_b, cmd_valid, rsp_valid, mem_acc, mem_fail, acc, fetch, bnd, tag_end, low_pwr;
   logic tag, enter, resume, trace, act, clk_sel, v;
   logic [7:0] code;
   logic [15:0] wdata, rdata, addr, r;
   int n_mismatch = 0;
   int check_count = 0;
   // Free-running 50 MHz clock
   always #10 clk = ~clk;
   dbgbk_top dbgbk_top_i (.CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cmd_valid),
      .CMD_CODE_I(code), .CMD_WDATA_I(wdata), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rdata),
      .MEM_ACC_I(mem_acc), .MEM_ACC_FAIL_O(mem_fail), .CPU_ADDR_I(addr), .CPU_ACCESS_I(acc),
      .CPU_FETCH_I(fetch), .CPU_BOUNDARY_I(bnd), .CPU_TAG_AT_END_I(tag_end),
      .CPU_LOW_POWER_I(low_pwr), .TAG_O(tag), .HALT_ENTER_O(enter), .RESUME_O(resume),
      .TRACE_O(trace), .HALT_ACTIVE_O(act), .DEBUG_CLK_SEL_O(clk_sel));
   dbgbk_host dbgbk_host_i (.clk_i(clk), .rsp_valid_i(rsp_valid), .rsp_data_i(rdata),
      .cmd_valid_o(cmd_valid), .cmd_code_o(code), .cmd_wdata_o(wdata));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Flags in order tag, enter, resume, trace, halted
   task automatic fl(input logic [4:0] e);
      chk({11'h000, tag, enter, resume, trace, act}, {11'h000, e});
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      dbgbk_host_i.send(c, 16'h0000, v, r);
      chk({15'h0000, v}, 16'h0001);
      chk(r, e);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      dbgbk_host_i.send(c, d, v, r);
   endtask
   // One CPU cycle {access, fetch, boundary, tag at end}; returns once its effects show
   task automatic cpu(input logic [3:0] k);
      @(negedge clk);
      {acc, fetch, bnd, tag_end} = k;
      @(negedge clk);
      {acc, fetch, bnd, tag_end} = 4'h0;
   endtask
   task automatic mem(input logic e);
      @(negedge clk);
      mem_acc = 1'b1;
      @(negedge clk);
      mem_acc = 1'b0;
      chk({15'h0000, mem_fail}, {15'h0000, e});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence; every latency is fixed, so no open waits are needed
   initial begin
      rst_b = 1'b0;
      {mem_acc, acc, fetch, bnd, tag_end, low_pwr} = 6'h00;
      addr = 16'ha5c3;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      rd(CMD_READ_STATUS, 16'h0000);
      rd(CMD_MATCH_READ, 16'h0000);
      wr(CMD_MATCH_WRITE, 16'ha5c3);
      rd(CMD_MATCH_READ, 16'ha5c3);
      wr(CMD_WRITE_CONTROL, 16'h00ff);
      rd(CMD_READ_STATUS, 16'h00b8);
      chk({15'h0000, clk_sel}, 16'h0001);
      $display("registers done");
      wr(CMD_WRITE_CONTROL, 16'h0090);
      chk({15'h0000, clk_sel}, 16'h0000);
      cpu(4'h8);
      cpu(4'h2);
      fl(5'h00);
      wr(CMD_WRITE_CONTROL, 16'h00b0);
      cpu(4'h8);
      cpu(4'h0);
      cpu(4'h2);
      fl(5'h09);
      rd(CMD_READ_STATUS, 16'h00f0);
      wr(CMD_WRITE_CONTROL, 16'h0030);
      rd(CMD_READ_STATUS, 16'h00f0);
      cpu(4'ha);
      fl(5'h01);
      wr(CMD_RESUME, 16'h0000);
      fl(5'h04);
      addr = 16'ha5c2;
      cpu(4'ha);
      fl(5'h00);
      addr = 16'h25c3;
      cpu(4'ha);
      fl(5'h00);
      addr = 16'ha5c3;
      $display("forced done");
      wr(CMD_WRITE_CONTROL, 16'h00a0);
      cpu(4'hc);
      fl(5'h10);
      cpu(4'h1);
      fl(5'h09);
      wr(CMD_TRACE_ONE, 16'h0000);
      fl(5'h06);
      $display("tagged done");
      wr(CMD_WRITE_CONTROL, 16'h0000);
      wr(CMD_HALT_REQUEST, 16'h0000);
      fl(5'h00);
      low_pwr = 1'b1;
      mem(1'b1);
      wr(CMD_WRITE_CONTROL, 16'h0080);
      wr(CMD_HALT_REQUEST, 16'h0000);
      fl(5'h09);
      low_pwr = 1'b0;
      rd(CMD_READ_STATUS, 16'h00c6);
      mem(1'b0);
      rd(CMD_READ_STATUS, 16'h00c4);
      wr(CMD_RESUME_TAGGED, 16'h0000);
      fl(5'h04);
      $display("low power done");
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      rd(CMD_READ_STATUS, 16'h0000);
      rd(CMD_MATCH_READ, 16'h0000);
      $display("reset done");
      give_verdict();
   end
endmodule
